// ### rtl/pwrseq_pkg.sv
/*
  Constants, types and the strap decode for the module power and boot
  sequencer. Assumes a single 250 MHz system clock and an APB register port.
*/
package pwrseq_pkg;

  // Clock rate
  localparam longint CLK_HZ            = 250_000_000;

  // Timing: carrier supply settle time before reset release
  localparam longint SETTLE_NS         = 1000;
  localparam int     SETTLE_CYCLES     =
    int'((SETTLE_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);

  // Timing: power button hold time for forced power off
  localparam longint BTN_HOLD_S        = 5;
  localparam int     BTN_HOLD_CYCLES   = int'(BTN_HOLD_S * CLK_HZ);

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // Control register fields and reset value
  localparam int          CTRL_SUSPEND_BIT = 0;
  localparam int          CTRL_POWEROFF_BIT = 1;
  localparam logic [1:0]  CTRL_RESET       = 2'h0;

  // Status register fields
  localparam int STAT_FAULT_BIT   = 0;
  localparam int STAT_RSTREQ_BIT  = 1;
  localparam int STAT_BTN_BIT     = 2;
  localparam int STAT_RECOV_BIT   = 3;
  localparam int STAT_BOOT_LSB    = 4;
  localparam int STAT_FUSE_BIT    = 7;
  localparam int STAT_STATE_LSB   = 8;

  // Synchronised input vector layout
  localparam int IN_FAULT  = 0;
  localparam int IN_RSTREQ = 1;
  localparam int IN_BTN    = 2;
  localparam int IN_RECOV  = 3;
  localparam int IN_STRAP  = 4;
  localparam int IN_WIDTH  = 7;
  // Fault reads as asserted during reset, all else as released
  localparam logic [IN_WIDTH-1:0] IN_RESET = 7'h7E;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_POWER_UP,
    ST_CARRIER_ON,
    ST_RUN,
    ST_SUSPEND,
    ST_HALT
  } seq_state_t;

  typedef enum logic [2:0] {
    BOOT_FUSED,
    BOOT_SPI_FLASH,
    BOOT_SD_CARD,
    BOOT_EMMC,
    BOOT_SERIAL_DL,
    BOOT_UNDEFINED
  } boot_src_t;

  // Straps are {sel2, sel1, sel0}; 1 = floating, 0 = grounded
  function automatic boot_src_t strap_decode(input logic [2:0] straps,
                                             input logic       recov_n);
    boot_src_t src;
    src = BOOT_UNDEFINED;
    if (!recov_n) begin
      src = BOOT_SERIAL_DL;
    end else if (straps == 3'h7) begin
      src = BOOT_FUSED;
    end else if (straps == 3'h1) begin
      src = BOOT_SPI_FLASH;
    end else if (straps == 3'h4) begin
      src = BOOT_SD_CARD;
    end else if (straps == 3'h5) begin
      src = BOOT_EMMC;
    end else if (straps == 3'h6) begin
      src = BOOT_SERIAL_DL;
    end
    return src;
  endfunction

endpackage

// ### rtl/sync_bus_if.sv
/*
  Carrier of synchronised carrier-board inputs between the synchroniser
  and the sequencer. Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface sync_bus_if #(parameter int WIDTH = 7);
  logic [WIDTH-1:0] level;
  modport producer (output level);
  modport consumer (input  level);
endinterface
`default_nettype wire

// ### rtl/input_sync_bank.sv
/*
  Two-stage synchroniser bank for asynchronous carrier pins.
  Assumes pins are quasi-static compared with the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module input_sync_bank
  import pwrseq_pkg::*;
#(
  parameter int               WIDTH   = IN_WIDTH,
  parameter logic [WIDTH-1:0] RST_VAL = IN_RESET
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Raw pins
  input  wire logic [WIDTH-1:0] pins,
  // Synchronised levels
  sync_bus_if.producer          sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("input_sync_bank: WIDTH must be at least 1");
    end
  endgenerate

  // Two flops per pin; only the second stage is read [R19]
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          meta_q[i]   <= RST_VAL[i];
          stable_q[i] <= RST_VAL[i];
        end else begin
          meta_q[i]   <= pins[i];
          stable_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out.level = stable_q;

endmodule
`default_nettype wire

// ### rtl/module_power_boot_sequencer.sv
/*
  Power-up, reset, power-button and boot-source sequencer of the module,
  with an APB control and status port.
  Assumes carrier pins are asynchronous and sys_rst is held while the
  module clock starts.
*/
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: Power circuits stay disabled while the input power fault is low.
// R2: Carrier holds the power fault low until its supply is stable.
// R3: Once power is good, sequencing starts without any carrier request.
// R4: Next step raises carrier supply enable and standby to run levels.
// R5: Carrier supply enable is active high and switches carrier supplies.
// R6: Standby output goes low to signal the suspend state.
// R7: Carrier reset stays low through power-up; released only to boot.
// R8: Carrier reset is released only after carrier enables are up.
// R9: A low reset request forces the module back into reset.
// R10: Boot waits while the reset request is still low.
// R11: A low power button wakes the system.
// R12: Button low for five seconds powers the system off at once.
// R13: Straps all floating select fused default; 1,2 grounded select flash.
// R14: Straps 0,1 grounded SD; only 1 grounded eMMC; only 0 download.
// R15: Fused default resolves to booting from the serial flash.
// R16: Low recovery-force selects serial download regardless of straps.
// R17: Carrier keeps recovery-force high for normal booting.
// R18: Serial download mode takes its image over the first USB port.
// R19: Asynchronous carrier inputs pass two flip-flops before use.
// R20: Straps are sampled once at reset release and then held.
// R21: Button hold counter runs on the module clock, clears when high.
module module_power_boot_sequencer
  import pwrseq_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES,
  parameter int HOLD   = BTN_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Carrier inputs
  input  wire logic        input_power_fault_n,
  input  wire logic        reset_request_n,
  input  wire logic        power_button_n,
  input  wire logic        recovery_force_n,
  input  wire logic [2:0]  boot_strap_n,
  // Carrier outputs
  output logic             power_circuit_enable,
  output logic             carrier_supply_enable,
  output logic             carrier_standby_n,
  output logic             carrier_reset_n,
  // Boot selection
  output logic [2:0]       boot_source,
  output logic             boot_fuse_default,
  output logic             first_usb_port_download,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  generate
    if (SETTLE < 1 || SETTLE > 65535) begin : g_bad_settle
      $error("SETTLE must be within 1 to 65535 cycles");
    end
    if (HOLD < 2) begin : g_bad_hold
      $error("HOLD must be at least 2 cycles");
    end
  endgenerate

  sync_bus_if #(.WIDTH(IN_WIDTH)) sync_bus ();

  input_sync_bank #(.WIDTH(IN_WIDTH), .RST_VAL(IN_RESET)) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .pins     ({boot_strap_n, recovery_force_n, power_button_n,
                reset_request_n, input_power_fault_n}),
    .sync_out (sync_bus.producer)
  );

  logic       fault_s;
  logic       rstreq_s;
  logic       btn_s;
  logic       recov_s;
  logic [2:0] strap_s;

  assign fault_s  = sync_bus.level[IN_FAULT];
  assign rstreq_s = sync_bus.level[IN_RSTREQ];
  assign btn_s    = sync_bus.level[IN_BTN];
  assign recov_s  = sync_bus.level[IN_RECOV];
  assign strap_s  = sync_bus.level[IN_STRAP +: 3];

  seq_state_t  state_q;
  seq_state_t  state_d;
  logic [15:0] settle_q;
  logic [31:0] btn_cnt_q;
  logic        btn_prev_q;
  logic        btn_armed_q;
  logic [1:0]  ctrl_q;
  boot_src_t   boot_raw_q;
  logic        btn_long;
  logic        wake_press;
  logic        settled;
  logic        apb_write;

  // Hold time counted on the module clock, cleared while high [R21]
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      btn_cnt_q <= 32'h0;
    end else if (btn_s) begin
      btn_cnt_q <= 32'h0;
    end else if (btn_cnt_q != 32'(HOLD - 1)) begin
      btn_cnt_q <= btn_cnt_q + 32'h1;
    end
  end

  // A press only wakes after the button was seen released
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      btn_prev_q  <= 1'b1;
      btn_armed_q <= 1'b0;
    end else begin
      btn_prev_q <= btn_s;
      if (btn_long) begin
        btn_armed_q <= 1'b0;
      end else if (btn_s) begin
        btn_armed_q <= 1'b1;
      end
    end
  end

  assign btn_long   = !btn_s && (btn_cnt_q == 32'(HOLD - 1));  // [R12]
  assign wake_press = !btn_s && btn_prev_q && btn_armed_q;     // [R11]
  assign settled    = (settle_q == 16'(SETTLE - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (fault_s) begin
          state_d = ST_POWER_UP;                       // [R3]
        end
      end
      ST_POWER_UP: begin
        if (settled) begin
          state_d = ST_CARRIER_ON;                     // [R4]
        end
      end
      ST_CARRIER_ON: begin
        if (settled && rstreq_s) begin
          state_d = ST_RUN;                            // [R8] [R10]
        end
      end
      ST_RUN: begin
        if (ctrl_q[CTRL_SUSPEND_BIT]) begin
          state_d = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (wake_press) begin
          state_d = ST_RUN;                            // [R11]
        end
      end
      ST_HALT: begin
        if (wake_press) begin
          state_d = ST_POWER_UP;                       // [R11]
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (state_q inside {ST_CARRIER_ON, ST_RUN, ST_SUSPEND}) begin
      if (btn_long || ctrl_q[CTRL_POWEROFF_BIT]) begin
        state_d = ST_HALT;                             // [R12]
      end else if (!rstreq_s && state_q != ST_CARRIER_ON) begin
        state_d = ST_CARRIER_ON;                       // [R9]
      end
    end
    if (!fault_s) begin
      state_d = ST_OFF;                                // [R1]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Settle counter restarts on every state change
  always_ff @(posedge clk_sys) begin
    if (sys_rst || state_d != state_q) begin
      settle_q <= 16'h0;
    end else if (!settled) begin
      settle_q <= settle_q + 16'h1;
    end
  end

  // Carrier pins follow the next state so they line up with state_q
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      power_circuit_enable  <= 1'b0;
      carrier_supply_enable <= 1'b0;
      carrier_standby_n     <= 1'b0;
      carrier_reset_n       <= 1'b0;
    end else begin
      power_circuit_enable  <= (state_d != ST_OFF);    // [R1]
      carrier_supply_enable <= state_d inside
        {ST_CARRIER_ON, ST_RUN, ST_SUSPEND};           // [R4] [R5]
      carrier_standby_n     <= state_d inside
        {ST_CARRIER_ON, ST_RUN};                       // [R4] [R6]
      carrier_reset_n       <= state_d inside
        {ST_RUN, ST_SUSPEND};                          // [R7]
    end
  end

  // Straps caught once, at the edge that releases the carrier reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      boot_raw_q <= BOOT_UNDEFINED;
    end else if (state_d == ST_RUN && !carrier_reset_n) begin
      boot_raw_q <= strap_decode(strap_s, recov_s);    // [R13] [R14] [R16] [R20]
    end
  end

  // Fused default resolves to the serial flash
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      boot_source             <= 3'(BOOT_UNDEFINED);
      boot_fuse_default       <= 1'b0;
      first_usb_port_download <= 1'b0;
    end else begin
      boot_source       <= (boot_raw_q == BOOT_FUSED) ?
                           3'(BOOT_SPI_FLASH) : 3'(boot_raw_q);  // [R15]
      boot_fuse_default <= (boot_raw_q == BOOT_FUSED);
      first_usb_port_download <= (boot_raw_q == BOOT_SERIAL_DL) &&
                                 carrier_reset_n;                // [R18]
    end
  end

  // APB: ready comes one cycle after setup, no wait states
  assign apb_write = psel && penable && pready && pwrite;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      if (apb_write && paddr == CTRL_OFFSET) begin
        ctrl_q <= pwdata[1:0];
      end
      if (state_q == ST_SUSPEND && state_d == ST_RUN) begin
        ctrl_q[CTRL_SUSPEND_BIT] <= 1'b0;
      end
      if (state_d == ST_HALT || state_d == ST_OFF) begin
        ctrl_q <= CTRL_RESET;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable) begin
        if (paddr == CTRL_OFFSET) begin
          prdata[1:0] <= ctrl_q;
        end else if (paddr == STATUS_OFFSET) begin
          prdata[STAT_FAULT_BIT]  <= fault_s;
          prdata[STAT_RSTREQ_BIT] <= rstreq_s;
          prdata[STAT_BTN_BIT]    <= btn_s;
          prdata[STAT_RECOV_BIT]  <= recov_s;
          prdata[STAT_BOOT_LSB +: 3] <= boot_source;
          prdata[STAT_FUSE_BIT]   <= boot_fuse_default;
          prdata[STAT_STATE_LSB +: 3] <= 3'(state_q);
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_release;
    !carrier_reset_n ##1 carrier_reset_n;
  endsequence

  sequence s_held_long;
    btn_long && fault_s &&
      state_q inside {ST_CARRIER_ON, ST_RUN, ST_SUSPEND};
  endsequence

  a_fault_disables: assert property (!fault_s |=> !power_circuit_enable && !carrier_supply_enable) else $error("power on during fault"); // [R1]
  a_auto_start: assert property (state_q == ST_OFF && fault_s |=> state_q == ST_POWER_UP ##[1:300] carrier_supply_enable || !fault_s) else $error("no automatic start"); // [R3]
  a_enable_pair: assert property ($rose(carrier_supply_enable) |-> carrier_standby_n && !carrier_reset_n) else $error("enables not paired"); // [R4] [R5]
  a_suspend_standby: assert property (state_q == ST_SUSPEND |-> !carrier_standby_n && carrier_supply_enable) else $error("suspend not signalled"); // [R6]
  a_reset_in_powerup: assert property (state_q inside {ST_POWER_UP, ST_CARRIER_ON} |-> !carrier_reset_n) else $error("reset released early"); // [R7]
  a_release_order: assert property (s_release |-> $past(carrier_supply_enable, 2) && carrier_supply_enable) else $error("reset before enables"); // [R8]
  a_reset_request: assert property (!rstreq_s && fault_s |=> !carrier_reset_n) else $error("reset request ignored"); // [R9] [R10]
  a_wake_suspend: assert property (state_q == ST_SUSPEND && wake_press && rstreq_s && fault_s && !btn_long |=> state_q == ST_RUN ##1 carrier_standby_n) else $error("no wake"); // [R11]
  a_long_press_off: assert property (s_held_long |=> !carrier_supply_enable && !carrier_reset_n) else $error("long press ignored"); // [R12]
  a_strap_decode: assert property (s_release |-> boot_raw_q == strap_decode($past(strap_s), $past(recov_s))) else $error("wrong boot source"); // [R13] [R14] [R16]
  a_fuse_flash: assert property (boot_raw_q == BOOT_FUSED |=> boot_source == 3'(BOOT_SPI_FLASH)) else $error("fuse default wrong"); // [R15]
  a_boot_held: assert property (carrier_reset_n && $past(carrier_reset_n) |-> $stable(boot_raw_q)) else $error("boot source changed"); // [R20]
  a_usb_download: assert property (first_usb_port_download |-> $past(boot_raw_q) == BOOT_SERIAL_DL) else $error("usb download wrong"); // [R18]
  a_counter_clear: assert property (btn_s |=> btn_cnt_q == 32'h0) else $error("counter not cleared"); // [R21]

endmodule
`default_nettype wire

// ### verif/carrier_board_model.sv
/*
  Behavioural carrier board: power-fault, reset request, button, recovery
  and strap pins, steered by the bench. Assumes one clock, pins change
  right after its rising edge; straps read 1 when floating (pull-ups).
*/
`timescale 1ns/100ps
`default_nettype none
module carrier_board_model (
  // Clock
  input  wire logic       clk_sys,
  // Bench commands
  input  wire logic       supply_up,
  input  wire logic       req_reset,
  input  wire logic       press,
  input  wire logic       recover,
  input  wire logic [2:0] straps,
  // Carrier pins
  output logic            input_power_fault_n,
  output logic            reset_request_n,
  output logic            power_button_n,
  output logic            recovery_force_n,
  output logic [2:0]      boot_strap_n
);
  initial begin
    input_power_fault_n = 1'b0;
    reset_request_n     = 1'b1;
    power_button_n      = 1'b1;
    recovery_force_n    = 1'b1;
    boot_strap_n        = 3'h7;
  end
  always @(posedge clk_sys) begin
    input_power_fault_n <= supply_up;
    reset_request_n     <= ~req_reset;
    power_button_n      <= ~press;
    recovery_force_n    <= ~recover;
    boot_strap_n        <= straps;
  end
endmodule
`default_nettype wire

// ### verif/module_power_boot_sequencer_test.sv
/*
  Self-checking bench of the power and boot sequencer with an APB master.
  Assumes the carrier model in its own file and short SETTLE/HOLD counts.
*/
`timescale 1ns/100ps
`default_nettype none
module module_power_boot_sequencer_test;
  import pwrseq_pkg::*;
  localparam int SET = 4;
  localparam int HLD = 20;
  logic clk_sys = 1'b0, sys_rst = 1'b1;
  logic supply_up = 1'b0, req_reset = 1'b0, press = 1'b0, recover = 1'b0;
  logic [2:0] straps = 3'h7;
  wire logic fault_n, rreq_n, btn_n, recov_n;
  wire logic [2:0] strap_n;
  logic pce, cse, stby_n, crst_n, fuse, usb, pready, pslverr;
  logic [2:0] boot;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int n_mismatch = 0, samples_checked = 0;

  always #2 clk_sys = ~clk_sys;

  carrier_board_model i_carrier_board_model (.clk_sys(clk_sys),
    .supply_up(supply_up), .req_reset(req_reset), .press(press),
    .recover(recover), .straps(straps), .input_power_fault_n(fault_n),
    .reset_request_n(rreq_n), .power_button_n(btn_n),
    .recovery_force_n(recov_n), .boot_strap_n(strap_n));

  module_power_boot_sequencer #(.SETTLE(SET), .HOLD(HLD))
    i_module_power_boot_sequencer (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .input_power_fault_n(fault_n), .reset_request_n(rreq_n),
    .power_button_n(btn_n), .recovery_force_n(recov_n),
    .boot_strap_n(strap_n), .power_circuit_enable(pce),
    .carrier_supply_enable(cse), .carrier_standby_n(stby_n),
    .carrier_reset_n(crst_n), .boot_source(boot),
    .boot_fuse_default(fuse), .first_usb_port_download(usb),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Wait for an output level, bounded
  task automatic wait_sig(input int sel, input logic val);
    logic s;
    for (int i = 0; i < 200; i++) begin
      @(negedge clk_sys);
      case (sel)
        0: s = pce;
        1: s = cse;
        2: s = crst_n;
        default: s = stby_n;
      endcase
      if (s === val) return;
    end
    check(32'h0, 32'h1);
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic err);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    check(i < 50, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_power_up();
    cyc(10);
    check(pce, 1'b0);
    check(crst_n, 1'b0);
    @(posedge clk_sys) supply_up <= 1'b1;
    wait_sig(0, 1'b1);
    check(crst_n, 1'b0);
    wait_sig(1, 1'b1);
    check(stby_n, 1'b1);
    check(crst_n, 1'b0);
    wait_sig(2, 1'b1);
    cyc(2);
    check(boot, BOOT_SPI_FLASH);
  endtask

  // Straps, unused bit, expected source, fused flag; recovery forced only on the last entry
  task automatic t_straps();
    logic [7:0] tbl [7] = '{8'hE3, 8'h22, 8'h84, 8'hA6, 8'hC8, 8'h0A,
                            8'h08};
    for (int k = 0; k < 7; k++) begin
      @(posedge clk_sys);
      straps <= tbl[k][7:5];
      recover <= (k == 6);
      req_reset <= 1'b1;
      cyc(6);
      check(crst_n, 1'b0);
      cyc(12);
      check(crst_n, 1'b0);
      @(posedge clk_sys) req_reset <= 1'b0;
      wait_sig(2, 1'b1);
      cyc(2);
      check(boot, tbl[k][3:1]);
      check(fuse, tbl[k][0]);
      check(usb, tbl[k][3:1] == BOOT_SERIAL_DL);
    end
    @(posedge clk_sys);
    straps <= 3'h5;
    recover <= 1'b0;
    cyc(8);
    check(boot, BOOT_SERIAL_DL);
  endtask

  task automatic t_apb_suspend();
    logic e;
    apb(1'b0, STATUS_OFFSET, 32'h0, e);
    check(rd[10:8], 3'h3);
    check(rd[3:0], 4'hF);
    check(rd[7:4], 4'h4);
    check(e, 1'b0);
    apb(1'b0, 8'h08, 32'h0, e);
    check(e, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, CTRL_OFFSET, 32'h1, e);
    wait_sig(3, 1'b0);
    check(cse, 1'b1);
    @(posedge clk_sys) press <= 1'b1;
    cyc(5);
    @(posedge clk_sys) press <= 1'b0;
    wait_sig(3, 1'b1);
  endtask

  task automatic t_long_press();
    logic e;
    @(posedge clk_sys) press <= 1'b1;
    cyc(HLD - 4);
    @(posedge clk_sys) press <= 1'b0;
    cyc(4);
    @(posedge clk_sys) press <= 1'b1;
    cyc(HLD - 4);
    check(cse, 1'b1);
    cyc(12);
    check(cse, 1'b0);
    check(crst_n, 1'b0);
    @(posedge clk_sys) press <= 1'b0;
    cyc(6);
    @(posedge clk_sys) press <= 1'b1;
    cyc(4);
    @(posedge clk_sys) press <= 1'b0;
    wait_sig(2, 1'b1);
    apb(1'b1, CTRL_OFFSET, 32'h2, e);
    wait_sig(1, 1'b0);
    check(crst_n, 1'b0);
    check(pce, 1'b1);
    apb(1'b0, CTRL_OFFSET, 32'h0, e);
    check(rd, 32'h0);
    @(posedge clk_sys) supply_up <= 1'b0;
    cyc(6);
    check({pce, cse, stby_n, crst_n}, 4'h0);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_power_up();
    t_straps();
    t_apb_suspend();
    t_long_press();
    print_verdict();
  end

  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
